/* File: design/rtc_cfg.svh */
// offsets, field positions, reset values and timing counts of the clock core
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

// map offsets
`define RTC_OFS_SEC 7'h00
`define RTC_OFS_SEC_ALM 7'h01
`define RTC_OFS_MIN 7'h02
`define RTC_OFS_MIN_ALM 7'h03
`define RTC_OFS_HOUR 7'h04
`define RTC_OFS_HOUR_ALM 7'h05
`define RTC_OFS_A 7'h0A
`define RTC_OFS_B 7'h0B
`define RTC_OFS_C 7'h0C
`define RTC_OFS_D 7'h0D
`define RTC_NUM_TIME 7'h0A

// field positions
`define RTC_A_UIP 7
`define RTC_B_SET 7
`define RTC_B_PIE 6
`define RTC_B_AIE 5
`define RTC_B_UIE 4
`define RTC_B_SQUARE_WAVE_ENABLE 3
`define RTC_B_DM 2
`define RTC_B_H24 1
`define RTC_C_ANY_INTERRUPT_FLAG 7

// codes and reset values
`define RTC_DV_RUN 3'h2
`define RTC_DV_HOLD 2'h3
`define RTC_DONT_CARE 2'h3
`define RTC_A_RST 7'h26
`define RTC_B_RST 8'h02
`define RTC_D_VAL 8'h80
`define RTC_CHAIN_HALF 15'h4000
`define RTC_CHAIN_LAST 15'h7FFF

// timing
`define RTC_CLK_HZ 50000000
`define RTC_CLK_MHZ 50
`define RTC_OSC_HZ 32768
`define RTC_PRESC_CYC ((`RTC_CLK_HZ + `RTC_OSC_HZ / 2) / `RTC_OSC_HZ)
`define RTC_UIP_LEAD_US 244
`define RTC_UIP_LEAD_CYC (`RTC_UIP_LEAD_US * `RTC_CLK_MHZ)

`endif

/* File: design/rtc_pkg.sv */
// types of the clock core
package rtc_pkg;

  typedef enum logic {RTC_UPD_IDLE, RTC_UPD_LEAD} rtc_upd_t;

  // host bus pins as sampled
  typedef struct packed {
    logic as;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [7:0] ad;
  } rtc_bus_t;

  typedef struct packed {
    logic [9:0][7:0] vis;
    logic [9:0][7:0] cnt;
    logic [6:0] ctl_a;
    logic [7:0] ctl_b;
    logic update_pending;
    logic [2:0] flg;
    logic [2:0] pend;
    logic rd_c;
    logic irq_oe;
    logic irq_n;
    logic [6:0] addr;
    logic as_q;
    logic rd_n_q;
    logic wr_n_q;
    logic [7:0] rdata;
    logic drive;
    logic [10:0] presc;
    logic [14:0] chain;
    rtc_upd_t upd;
    logic [13:0] lead;
  } rtc_state_t;

endpackage

/* File: design/rtc_core.sv */
// real-time clock core with calendar, alarm and interrupt flags
`timescale 1ns/10ps
`include "rtc_cfg.svh"

module rtc_core #(
  parameter int unsigned UIP_LEAD_CYC = `RTC_UIP_LEAD_CYC,
  parameter int unsigned PRESC_CYC = `RTC_PRESC_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // device pins
  input wire logic reset_n_i,
  input wire rtc_pkg::rtc_bus_t bus_i,
  // data bus drive
  output logic [7:0] ad_o,
  output logic ad_oe_o,
  // open-drain interrupt
  output logic irq_n_o,
  output logic irq_oe_o
);

  rtc_pkg::rtc_state_t st;
  rtc_pkg::rtc_state_t n;
  logic [7:0] ram [0:127];
  logic wr_fire;
  logic rd_end;
  logic [2:0] ev;
  logic [7:0] live_c;

  function automatic logic [7:0] to_bin(input logic [7:0] v, input logic bcd);
    to_bin = bcd ? 8'(({4'h0, v[7:4]} * 8'h0A) + {4'h0, v[3:0]}) : v;
  endfunction

  function automatic logic [7:0] from_bin(input logic [7:0] v,
                                          input logic bcd);
    from_bin = bcd ? {4'(v / 8'h0A), 4'(v % 8'h0A)} : v;
  endfunction

  // month length, leap years every fourth year of the two-digit count
  function automatic logic [7:0] mdays(input logic [7:0] mo,
                                       input logic [7:0] yr);
    case (mo)
      8'h02: mdays = (yr[1:0] == 2'h0) ? 8'h1D : 8'h1C;
      8'h04, 8'h06, 8'h09, 8'h0B: mdays = 8'h1E;
      default: mdays = 8'h1F;
    endcase
  endfunction

  function automatic logic alm_hit(input logic [7:0] a, input logic [7:0] t);
    alm_hit = (a[7:6] == `RTC_DONT_CARE) || (a == t);
  endfunction

  // low-bit mask of the chain for the selected periodic rate
  function automatic logic [14:0] per_mask(input logic [3:0] rs);
    logic [3:0] e;
    e = (rs < 4'h3) ? 4'(rs + 4'h6) : 4'(rs - 4'h1);
    per_mask = 15'((16'h0001 << e) - 16'h0001);
  endfunction

  // one second of advance in the selected number format
  function automatic logic [9:0][7:0] adv(input logic [9:0][7:0] t,
                                          input logic bcd,
                                          input logic h24);
    logic [9:0][7:0] r;
    logic [7:0] v;
    logic [7:0] dt;
    logic [7:0] mo;
    logic [7:0] yr;
    logic c;
    logic pm;
    r = t;
    v = to_bin(t[0], bcd);
    c = v >= 8'h3B;
    r[0] = from_bin(c ? 8'h00 : 8'(v + 8'h01), bcd);
    if (c) begin
      v = to_bin(t[2], bcd);
      c = v >= 8'h3B;
      r[2] = from_bin(c ? 8'h00 : 8'(v + 8'h01), bcd);
    end
    if (c) begin
      if (h24) begin
        v = to_bin(t[4], bcd);
        c = v >= 8'h17;
        r[4] = from_bin(c ? 8'h00 : 8'(v + 8'h01), bcd);
      end else begin
        // bit 7 carries PM; 11 to 12 flips it, 11 PM to 12 AM ends the day
        pm = t[4][7];
        v = to_bin({1'b0, t[4][6:0]}, bcd);
        c = (v == 8'h0B) && pm;
        if (v == 8'h0B) begin
          pm = ~pm;
        end
        v = (v >= 8'h0C) ? 8'h01 : 8'(v + 8'h01);
        r[4] = from_bin(v, bcd) | {pm, 7'h00};
      end
    end
    if (c) begin
      v = to_bin(t[6], bcd);
      r[6] = from_bin((v >= 8'h07) ? 8'h01 : 8'(v + 8'h01), bcd);
      dt = to_bin(t[7], bcd);
      mo = to_bin(t[8], bcd);
      yr = to_bin(t[9], bcd);
      c = dt >= mdays(mo, yr);
      r[7] = from_bin(c ? 8'h01 : 8'(dt + 8'h01), bcd);
      if (c) begin
        c = mo >= 8'h0C;
        r[8] = from_bin(c ? 8'h01 : 8'(mo + 8'h01), bcd);
      end
      if (c) begin
        r[9] = from_bin((yr >= 8'h63) ? 8'h00 : 8'(yr + 8'h01), bcd);
      end
    end
    adv = r;
  endfunction

  // next-state logic
  always_comb begin
    logic acc_ok;
    logic rd_act;
    logic tick;
    logic run;
    logic [14:0] ch;
    logic [9:0][7:0] nt;
    logic [7:0] d;
    logic [2:0] en;
    acc_ok = reset_n_i;
    n = st;
    ev = 3'h0;
    nt = st.cnt;
    d = bus_i.ad;
    n.as_q = bus_i.as;
    n.rd_n_q = bus_i.rd_n;
    n.wr_n_q = bus_i.wr_n;
    rd_act = acc_ok && !bus_i.cs_n && !bus_i.rd_n;
    rd_end = st.rd_c && bus_i.rd_n;
    wr_fire = acc_ok && !bus_i.cs_n && !st.wr_n_q && bus_i.wr_n;
    live_c = {st.irq_oe, st.flg, 4'h0};
    if (st.as_q && !bus_i.as) begin
      n.addr = bus_i.ad[6:0];
    end

    // oscillator and count-up divider chain
    run = st.ctl_a[6:4] == `RTC_DV_RUN;
    tick = 1'b0;
    if (run || st.ctl_a[6:5] == `RTC_DV_HOLD) begin
      tick = st.presc == 11'(PRESC_CYC - 1);
      n.presc = tick ? 11'h000 : 11'(st.presc + 11'h001);
    end
    ch = 15'(st.chain + 15'h0001);
    if (!run) begin
      // held chain restarts half a second before the next update
      n.chain = `RTC_CHAIN_HALF;
    end else if (tick) begin
      n.chain = ch;
      if (st.ctl_a[3:0] != 4'h0 && (ch & per_mask(st.ctl_a[3:0])) == 15'h0) begin
        ev[2] = 1'b1;
      end
    end

    // once a second raise update-pending unless SET is on, transfer after the lead time
    case (st.upd)
      rtc_pkg::RTC_UPD_IDLE: begin
        if (run && tick && st.chain == `RTC_CHAIN_LAST) begin
          n.upd = rtc_pkg::RTC_UPD_LEAD;
          n.lead = 14'h0000;
          n.update_pending = !st.ctl_b[`RTC_B_SET];
        end
      end
      rtc_pkg::RTC_UPD_LEAD: begin
        n.lead = 14'(st.lead + 14'h0001);
        if (st.lead == 14'(UIP_LEAD_CYC - 1)) begin
          n.upd = rtc_pkg::RTC_UPD_IDLE;
          n.update_pending = 1'b0;
          nt = adv(st.cnt, st.ctl_b[`RTC_B_DM], st.ctl_b[`RTC_B_H24]);
          n.cnt = nt;
          ev[1] = alm_hit(nt[1], nt[0]) && alm_hit(nt[3], nt[2])
                  && alm_hit(nt[5], nt[4]);
          if (!st.ctl_b[`RTC_B_SET]) begin
            n.vis = nt;
            ev[0] = 1'b1;
          end
        end
      end
      default: n.upd = rtc_pkg::RTC_UPD_IDLE;
    endcase

    // host writes
    if (wr_fire) begin
      if (st.addr < `RTC_NUM_TIME) begin
        // seconds bit 7 always stores zero
        if (st.addr == `RTC_OFS_SEC) begin
          d[7] = 1'b0;
        end
        n.vis[st.addr[3:0]] = d;
        n.cnt[st.addr[3:0]] = d;
      end else if (st.addr == `RTC_OFS_A) begin
        n.ctl_a = d[6:0];
      end else if (st.addr == `RTC_OFS_B) begin
        n.ctl_b = d;
        if (d[`RTC_B_SET]) begin
          n.ctl_b[`RTC_B_UIE] = 1'b0;
          n.update_pending = 1'b0;
        end
      end
    end

    // flags: held while a read of the flag register is open
    if (st.rd_c || (rd_act && st.addr == `RTC_OFS_C)) begin
      n.pend = st.pend | ev;
    end else begin
      n.flg = st.flg | ev;
    end
    if (rd_end) begin
      // clear wins only over what was seen; later events survive
      n.flg = st.pend | ev;
      n.pend = 3'h0;
      n.rd_c = 1'b0;
    end

    // host reads, registered one cycle behind the strobe
    n.drive = rd_act;
    if (rd_act) begin
      if (st.addr < `RTC_NUM_TIME) begin
        n.rdata = st.vis[st.addr[3:0]];
      end else if (st.addr == `RTC_OFS_A) begin
        n.rdata = {st.update_pending, st.ctl_a};
      end else if (st.addr == `RTC_OFS_B) begin
        n.rdata = st.ctl_b;
      end else if (st.addr == `RTC_OFS_C) begin
        n.rdata = st.rd_c ? st.rdata : live_c;
        n.rd_c = 1'b1;
      end else if (st.addr == `RTC_OFS_D) begin
        n.rdata = `RTC_D_VAL;
      end else begin
        n.rdata = ram[st.addr];
      end
    end

    if (!reset_n_i) begin
      n.ctl_b[`RTC_B_PIE] = 1'b0;
      n.ctl_b[`RTC_B_AIE] = 1'b0;
      n.ctl_b[`RTC_B_UIE] = 1'b0;
      n.ctl_b[`RTC_B_SQUARE_WAVE_ENABLE] = 1'b0;
      n.flg = 3'h0;
      n.pend = 3'h0;
      n.rd_c = 1'b0;
    end
    en = {n.ctl_b[`RTC_B_PIE], n.ctl_b[`RTC_B_AIE], n.ctl_b[`RTC_B_UIE]};
    n.irq_oe = |(n.flg & en);
    n.irq_n = 1'b0;
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.ctl_a <= `RTC_A_RST;
      st.ctl_b <= `RTC_B_RST;
      st.as_q <= 1'b0;
      st.rd_n_q <= 1'b1;
      st.wr_n_q <= 1'b1;
      st.chain <= `RTC_CHAIN_HALF;
      st.upd <= rtc_pkg::RTC_UPD_IDLE;
    end else begin
      st <= n;
    end
  end

  // general RAM keeps its contents through reset, being nonvolatile
  always_ff @(posedge clk_i) begin
    if (wr_fire && st.addr > `RTC_OFS_D) begin
      ram[st.addr] <= bus_i.ad;
    end
  end

  assign ad_o = st.rdata;
  assign ad_oe_o = st.drive;
  assign irq_n_o = st.irq_n;
  assign irq_oe_o = st.irq_oe;

  a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_oe_o == |(st.flg & {st.ctl_b[6], st.ctl_b[5], st.ctl_b[4]}))
    else $error("interrupt line disagrees with flags and enables");

  a_any_interrupt_flag_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.addr == `RTC_OFS_C) && !bus_i.cs_n && !bus_i.rd_n && st.rd_n_q
    && reset_n_i |=> ad_o[7] == $past(irq_oe_o))
    else $error("summary bit does not follow the interrupt line");

  a_read_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_end && ev == 3'h0 && reset_n_i |=> st.flg == $past(st.pend))
    else $error("flag read did not clear flags");

  a_sec_ro: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_fire && st.addr == `RTC_OFS_SEC |=> !st.vis[0][7] && !st.cnt[0][7])
    else $error("seconds bit 7 was written");

  a_reset_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    !reset_n_i |=> st.flg == 3'h0 && !irq_oe_o && st.ctl_b[6:3] == 4'h0)
    else $error("reset pin did not clear enables and flags");

  a_uip_lead: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(st.update_pending) |-> (st.upd == rtc_pkg::RTC_UPD_LEAD)[*8])
    else $error("transfer came too soon after update-pending");

  a_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
    st.ctl_b[`RTC_B_SET] && !wr_fire |=> $stable(st.vis))
    else $error("visible time changed while frozen");

  a_flags_ro: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_fire && st.addr == `RTC_OFS_C && ev == 3'h0 && !rd_end
    && reset_n_i |=> st.flg == $past(st.flg))
    else $error("write changed the flag register");

  a_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
    ev[0] && !st.rd_c && reset_n_i
    && !(st.addr == `RTC_OFS_C && !bus_i.cs_n && !bus_i.rd_n) |=> st.flg[0])
    else $error("update-ended event lost");

endmodule // rtc_core

/* File: verification/rtc_host_model.sv */
// host processor model driving the multiplexed address/data bus
`timescale 1ns/10ps

module rtc_host_model (
  // clock
  input wire logic clk_i,
  // extra strobe cycles, makes the host slow or prompt
  input wire logic [1:0] hold_i,
  // device answer
  input wire logic [7:0] ad_i,
  input wire logic ad_oe_i,
  // bus pins
  output rtc_pkg::rtc_bus_t bus_o
);
  logic as_r = 1'b0;
  logic cs_n_r = 1'b1;
  logic rd_n_r = 1'b1;
  logic wr_n_r = 1'b1;
  logic drv = 1'b0;
  logic [7:0] val = 8'h00;
  logic [7:0] pat = 8'h5A;

  // a released bus changes every cycle so no stale value reads as data
  always @(posedge clk_i) begin
    pat <= ~pat + 8'h01;
  end
  assign bus_o = '{as: as_r, cs_n: cs_n_r, rd_n: rd_n_r, wr_n: wr_n_r,
                   ad: drv ? val : pat};

  // address held through the cycle in which the strobe falls
  task automatic addr_phase(input logic [6:0] a);
    @(posedge clk_i);
    as_r <= 1'b1;
    drv <= 1'b1;
    val <= {1'b0, a};
    @(posedge clk_i);
    as_r <= 1'b0;
  endtask

  // data stays on the bus until after the write strobe rises
  task automatic host_write(input logic [6:0] a, input logic [7:0] d);
    addr_phase(a);
    @(posedge clk_i);
    cs_n_r <= 1'b0;
    wr_n_r <= 1'b0;
    val <= d;
    repeat (hold_i) @(posedge clk_i);
    @(posedge clk_i);
    wr_n_r <= 1'b1;
    @(posedge clk_i);
    cs_n_r <= 1'b1;
    drv <= 1'b0;
  endtask

  // data taken at the last edge of the read strobe, then released
  task automatic host_read(input logic [6:0] a, output logic [7:0] d,
                           output logic oe);
    addr_phase(a);
    @(posedge clk_i);
    cs_n_r <= 1'b0;
    rd_n_r <= 1'b0;
    drv <= 1'b0;
    repeat (hold_i) @(posedge clk_i);
    @(posedge clk_i);
    @(posedge clk_i);
    d = ad_i;
    oe = ad_oe_i;
    rd_n_r <= 1'b1;
    @(posedge clk_i);
    cs_n_r <= 1'b1;
  endtask
endmodule // rtc_host_model

/* File: verification/rtc_core_tb.sv */
// self-checking bench of the clock core against a host model
`timescale 1ns/10ps

module rtc_core_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic reset_n_i = 1'b1;
  logic [1:0] hold = 2'h0;
  rtc_pkg::rtc_bus_t bus;
  logic [7:0] ad;
  logic ad_oe;
  logic irq_n;
  logic irq_oe;
  logic irq_line;
  int mismatches = 0;
  int n_tests = 0;
  int i;
  logic [31:0] rnd = 32'h9187;
  logic [7:0] rd;
  logic [7:0] v;
  logic [6:0] ra;
  logic oe;

  always #10 clk_i = ~clk_i;
  // shared line with a pull-up
  assign irq_line = irq_oe ? irq_n : 1'b1;

  // one oscillator tick per clock makes a second 32768 cycles long
  rtc_core #(.UIP_LEAD_CYC(16), .PRESC_CYC(1)) DUT (.clk_i(clk_i),
    .rst_i(rst_i), .reset_n_i(reset_n_i), .bus_i(bus), .ad_o(ad),
    .ad_oe_o(ad_oe), .irq_n_o(irq_n), .irq_oe_o(irq_oe));
  rtc_host_model host (.clk_i(clk_i), .hold_i(hold), .ad_i(ad),
    .ad_oe_i(ad_oe), .bus_o(bus));

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // periodic flag only while the chain runs
  function automatic logic [7:0] exp_flags(input logic [2:0] dv);
    return (dv == 3'h2) ? 8'h40 : 8'h00;
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp,
                            input string what);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp,
                           input string what);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask

  // random strobe length keeps the host timing varied
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    rnd = xorshift(rnd);
    hold = rnd[1:0];
    host.host_write(a, d);
  endtask

  task automatic rdc(input logic [6:0] a, input logic [7:0] exp,
                     input string what);
    rnd = xorshift(rnd);
    hold = rnd[1:0];
    host.host_read(a, rd, oe);
    check_bit(oe, 1'b1, "bus drive");
    check_byte(rd, exp, what);
  endtask

  // bounded wait on the interrupt line; a miss ends the run
  task automatic wait_irq(input logic lvl, input int bound);
    int k;
    for (k = 0; k < bound && irq_line !== lvl; k++) @(posedge clk_i);
    check_bit(irq_line, lvl, "irq line");
    if (irq_line !== lvl) give_verdict();
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(7'h0A, 8'h26, "ctl a reset");
    rdc(7'h0B, 8'h02, "ctl b reset");
    rdc(7'h0C, 8'h00, "flags reset");
    rdc(7'h0D, 8'h80, "status");
    // stop the chain first so no flag can appear meanwhile
    wr(7'h0A, 8'h86);
    host.host_read(7'h0C, rd, oe);
    rdc(7'h0A, 8'h06, "ctl a top bit");
    wr(7'h0C, rnd[7:0]);
    rdc(7'h0C, 8'h00, "flags write");
    wr(7'h0D, rnd[15:8]);
    rdc(7'h0D, 8'h80, "status write");
    // time bytes written frozen, in binary and then in bcd
    for (i = 0; i < 2; i++) begin
      v = (i == 0) ? 8'h82 : 8'h86;
      wr(7'h0B, v);
      rdc(7'h0B, v, "ctl b");
      for (ra = 7'h01; ra < 7'h0A; ra++) begin
        v = rnd[7:0] % 8'h07 + 8'h01;
        wr(ra, v);
        rdc(ra, v, "time byte");
      end
    end
    wr(7'h00, 8'hBB);
    rdc(7'h00, 8'h3B, "seconds top bit");
    wr(7'h0B, 8'h02);
    // general ram, both ends of the range among random places
    for (i = 0; i < 12; i++) begin
      rnd = xorshift(rnd);
      v = rnd[7:0];
      ra = (i == 0) ? 7'h0E : (i == 1) ? 7'h7F : 7'h0E + 7'(rnd[15:8] % 8'h72);
      wr(ra, v);
      rdc(ra, v, "ram byte");
    end
    // every divider code at the fastest rate, stale flags cleared first
    for (i = 0; i < 8; i++) begin
      wr(7'h0A, {1'b0, 3'(i), 4'h3});
      host.host_read(7'h0C, rd, oe);
      repeat (200) @(posedge clk_i);
      rdc(7'h0C, exp_flags(3'(i)), "divider code");
    end
    // flag set while disabled, then enabled with the chain stopped
    wr(7'h0A, 8'h23);
    host.host_read(7'h0C, rd, oe);
    repeat (200) @(posedge clk_i);
    wr(7'h0A, 8'h03);
    check_bit(irq_line, 1'b1, "disabled source");
    wr(7'h0B, 8'h42);
    wait_irq(1'b0, 4);
    rdc(7'h0C, 8'hC0, "summary bit");
    wait_irq(1'b1, 4);
    rdc(7'h0C, 8'h00, "flags cleared");
    // device reset pin releases the line and blocks the bus
    wr(7'h0A, 8'h23);
    wait_irq(1'b0, 8000);
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    wait_irq(1'b1, 4);
    host.host_read(7'h0B, rd, oe);
    check_bit(oe, 1'b0, "access while held");
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    rdc(7'h0B, 8'h02, "enables cleared");
    // one update at 11 PM on the last day of February, 12-hour bcd
    wr(7'h0A, 8'h63);
    host.host_read(7'h0C, rd, oe);
    wr(7'h0B, 8'h84);
    wr(7'h00, 8'h59);
    wr(7'h01, 8'h00);
    wr(7'h02, 8'h59);
    wr(7'h03, 8'hC0);
    wr(7'h04, 8'h91);
    wr(7'h05, 8'hFF);
    wr(7'h06, 8'h07);
    wr(7'h07, 8'h28);
    wr(7'h08, 8'h02);
    wr(7'h09, 8'h01);
    wr(7'h0B, 8'h24);
    wr(7'h0A, 8'h20);
    wait_irq(1'b0, 17000);
    rdc(7'h0A, 8'h20, "pending low after transfer");
    rdc(7'h00, 8'h00, "seconds roll");
    rdc(7'h02, 8'h00, "minutes roll");
    rdc(7'h04, 8'h12, "midnight");
    rdc(7'h06, 8'h01, "weekday wrap");
    rdc(7'h07, 8'h01, "month day roll");
    rdc(7'h08, 8'h03, "month roll");
    rdc(7'h09, 8'h01, "year kept");
    rdc(7'h0C, 8'hB0, "alarm and update flags");
    wait_irq(1'b1, 4);
    give_verdict();
  end

  // hang guard
  initial begin
    repeat (60000) @(posedge clk_i);
    mismatches++;
    give_verdict();
  end
endmodule // rtc_core_tb
